//--- verilog/aotbs_pkg.sv
/*
 package for the adaptive on-time buck sequencer: timing constants, soft-start
 figures, supply clamp and the sequencer state type.
 assumes a 200 MHz core clock; every cycle count below is derived from that period.
*/
package aotbs_pkg;

    // core clock
    localparam int CLK_PERIOD_NS = 5;
    localparam int CLK_KHZ = 200000;

    // nominal switching rate used by the on-time estimate
    localparam int SW_KHZ = 300;

    // least times, rounded up to whole cycles
    localparam int MIN_OFF_NS = 363;
    localparam int MIN_OFF_CYC = (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_NS = 150;
    localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_NS = 30;
    localparam int DEAD_CYC = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // soft-start staircase: reference in microvolts, period in nanoseconds
    localparam int REF_FULL_UV = 800000;
    localparam int REF_STEP_UV = 9700;
    localparam int SS_STEPS = (REF_FULL_UV + REF_STEP_UV - 1) / REF_STEP_UV;
    localparam int SS_PERIOD_NS = 6000000;
    localparam int SS_STEP_CYC = (SS_PERIOD_NS + SS_STEPS * CLK_PERIOD_NS - 1)
        / (SS_STEPS * CLK_PERIOD_NS);

    // supply clamp for the on-time estimate, millivolts
    localparam int SUPPLY_CLAMP_MV = 30000;

    // widths
    localparam int MV_W = 16;
    localparam int TMR_W = 16;
    localparam int REF_W = 7;

    // reset values
    localparam logic [REF_W-1:0] REF_RESET = 7'h00;
    localparam logic [TMR_W-1:0] TMR_RESET = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ON,
        ST_DEAD_LS,
        ST_OFF,
        ST_DEAD_HS
    } aotbs_state_t;

endpackage

//--- verilog/aotbs_pin_sync.sv
/*
 three-stage synchroniser with agreement filter for one pin input.
 assumes the pin is asynchronous to clock; the output moves only when the
 second and third stages agree.
*/
module aotbs_pin_sync (
    input wire logic clock,
    input wire logic reset,
    input wire logic pin_async,
    output logic level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic level_next;

    // the first stage feeds only the second; the filter looks at stages two and three
    always_comb
    begin
        level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= pin_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level = level_reg;
endmodule

//--- verilog/aotbs_sequencer.sv
/*
 gate sequencer of a synchronous buck controller with adaptive on-time,
 minimum off time, dead time, current-limit hiccup and digital soft-start.
 assumes the comparator and current-limit inputs arrive asynchronously from
 analog circuitry, while the voltage estimates and enable come from logic
 on the same clock; the reference step count drives an external dac.
*/
// Contract
// - a comparator report of feedback below reference starts an on-interval, high side on.
// - the on-interval lasts output voltage over supply times 300 kHz.
// - after the on-interval the high side goes low and the low side high.
// - a new comparator report ends the off-interval and starts the next on-interval.
// - an off-interval is never shorter than about 363 ns.
// - if feedback stays low, the minimum off time and then the dead time pass before the next on.
// - the supply used in the estimate is clamped to 30 V.
// - at start-up the reference climbs from zero to 0.8 V in 9.7 mV steps over about 6 ms.
// - once the ramp ends its timer stops and the reference holds at full value.
// - after 150 ns blanking in each off-interval a current limit trip ends switching and restarts soft-start.
// - about 30 ns dead time separates one gate turning off from the other turning on.
module aotbs_sequencer #(
    parameter int SS_STEP_CYCLES = aotbs_pkg::SS_STEP_CYC
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic enable,
    input wire logic feedback_below_ref,
    input wire logic current_limit_trip,
    input wire logic [aotbs_pkg::MV_W-1:0] output_voltage_mv,
    input wire logic [aotbs_pkg::MV_W-1:0] power_stage_supply_mv,
    output logic high_side_gate_drive,
    output logic low_side_gate_drive,
    output logic [aotbs_pkg::REF_W-1:0] reference_step,
    output logic soft_start_done
);
    import aotbs_pkg::*;
    localparam logic [TMR_W-1:0] MIN_OFF = TMR_W'(MIN_OFF_CYC);
    localparam logic [TMR_W-1:0] BLANK = TMR_W'(BLANK_CYC);
    localparam logic [TMR_W-1:0] DEAD_LAST = TMR_W'(DEAD_CYC - 1);
    localparam logic [TMR_W-1:0] SS_LAST = TMR_W'(SS_STEP_CYCLES - 1);
    localparam logic [REF_W-1:0] REF_LAST = REF_W'(SS_STEPS);
    localparam logic [MV_W-1:0] CLAMP_MV = MV_W'(SUPPLY_CLAMP_MV);
    localparam logic [39:0] CLK_KHZ_W = 40'(CLK_KHZ);
    localparam logic [39:0] SW_KHZ_W = 40'(SW_KHZ);
    logic below_s;
    logic trip_s;
    // both analog inputs pass the same filtered synchroniser
    aotbs_pin_sync u_below_sync (
        .clock(clock),
        .reset(reset),
        .pin_async(feedback_below_ref),
        .level(below_s)
    );
    aotbs_pin_sync u_trip_sync (
        .clock(clock),
        .reset(reset),
        .pin_async(current_limit_trip),
        .level(trip_s)
    );
    // on-time estimate; the divider is registered so it never sits in the gate path
    logic [TMR_W-1:0] est_reg;
    logic [TMR_W-1:0] est_next;
    logic [MV_W-1:0] vin_cl;
    logic [39:0] num;
    logic [39:0] den;
    logic [39:0] quo;
    always_comb
    begin
        vin_cl = (power_stage_supply_mv > CLAMP_MV) ? CLAMP_MV : power_stage_supply_mv;
        if (vin_cl == 16'h0000)
        begin
            vin_cl = 16'h0001;
        end
        num = 40'(output_voltage_mv) * CLK_KHZ_W;
        den = 40'(vin_cl) * SW_KHZ_W;
        quo = (num + den - 40'h1) / den;
        if (quo == 40'h0)
        begin
            est_next = 16'h0001;
        end
        else if (quo > 40'h000000ffff)
        begin
            est_next = 16'hffff;
        end
        else
        begin
            est_next = quo[TMR_W-1:0];
        end
    end
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            est_reg <= 16'h0001;
        end
        else
        begin
            est_reg <= est_next;
        end
    end
    // soft-start staircase; the step timer sleeps once the top is reached
    logic [REF_W-1:0] ref_reg;
    logic [REF_W-1:0] ref_next;
    logic [TMR_W-1:0] ss_tmr_reg;
    logic [TMR_W-1:0] ss_tmr_next;
    logic done_reg;
    logic done_next;
    logic hiccup;
    always_comb
    begin
        ref_next = ref_reg;
        ss_tmr_next = ss_tmr_reg;
        done_next = done_reg;
        if (!enable || hiccup)
        begin
            ref_next = REF_RESET;
            ss_tmr_next = TMR_RESET;
            done_next = 1'b0;
        end
        else if (!done_reg)
        begin
            if (ss_tmr_reg == SS_LAST)
            begin
                ss_tmr_next = TMR_RESET;
                ref_next = ref_reg + 7'h01;
                done_next = (ref_reg + 7'h01 == REF_LAST);
            end
            else
            begin
                ss_tmr_next = ss_tmr_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            ref_reg <= REF_RESET;
            ss_tmr_reg <= TMR_RESET;
            done_reg <= 1'b0;
        end
        else
        begin
            ref_reg <= ref_next;
            ss_tmr_reg <= ss_tmr_next;
            done_reg <= done_next;
        end
    end
    // gate sequencer; off_reg counts from the high side turning off, not from low side on
    aotbs_state_t state_reg;
    aotbs_state_t state_next;
    logic [TMR_W-1:0] tmr_reg;
    logic [TMR_W-1:0] tmr_next;
    logic [TMR_W-1:0] off_reg;
    logic [TMR_W-1:0] off_next;
    logic [TMR_W-1:0] on_len_reg;
    logic [TMR_W-1:0] on_len_next;
    logic hs_reg;
    logic hs_next;
    logic ls_reg;
    logic ls_next;
    assign hiccup = (state_reg == ST_OFF) && (tmr_reg >= BLANK) && trip_s;
    always_comb
    begin
        state_next = state_reg;
        tmr_next = tmr_reg + 16'h0001;
        off_next = (off_reg < MIN_OFF) ? off_reg + 16'h0001 : off_reg;
        on_len_next = on_len_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (enable && below_s && tmr_reg >= DEAD_LAST)
                begin
                    state_next = ST_ON;
                    tmr_next = TMR_RESET;
                    on_len_next = est_reg;
                end
            end
            ST_ON:
            begin
                if (tmr_reg >= on_len_reg - 16'h0001)
                begin
                    state_next = ST_DEAD_LS;
                    tmr_next = TMR_RESET;
                    off_next = 16'h0001;
                end
            end
            ST_DEAD_LS:
            begin
                if (tmr_reg == DEAD_LAST)
                begin
                    state_next = ST_OFF;
                    tmr_next = TMR_RESET;
                end
            end
            ST_OFF:
            begin
                if (hiccup)
                begin
                    state_next = ST_IDLE;
                    tmr_next = TMR_RESET;
                end
                else if (below_s && off_reg >= MIN_OFF)
                begin
                    state_next = ST_DEAD_HS;
                    tmr_next = TMR_RESET;
                end
            end
            ST_DEAD_HS:
            begin
                if (tmr_reg == DEAD_LAST)
                begin
                    state_next = ST_ON;
                    tmr_next = TMR_RESET;
                    on_len_next = est_reg;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
        if (!enable)
        begin
            state_next = ST_IDLE;
            tmr_next = TMR_RESET;
        end
        hs_next = (state_next == ST_ON);
        ls_next = (state_next == ST_OFF);
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= ST_IDLE;
            tmr_reg <= TMR_RESET;
            off_reg <= MIN_OFF;
            on_len_reg <= 16'h0001;
            hs_reg <= 1'b0;
            ls_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            off_reg <= off_next;
            on_len_reg <= on_len_next;
            hs_reg <= hs_next;
            ls_reg <= ls_next;
        end
    end
    assign high_side_gate_drive = hs_reg;
    assign low_side_gate_drive = ls_reg;
    assign reference_step = ref_reg;
    assign soft_start_done = done_reg;
    // checks on the sequencer
    a_no_overlap: assert property (@(posedge clock) disable iff (reset) !(hs_reg && ls_reg))
        else $error("both gates driven together");
    a_dead_after_hs: assert property (@(posedge clock) disable iff (reset)
        $fell(hs_reg) |-> !ls_reg [*6])
        else $error("low side turned on inside dead time");
    a_dead_after_ls: assert property (@(posedge clock) disable iff (reset)
        $fell(ls_reg) |-> !hs_reg [*6]) else $error("high side turned on inside dead time");
    a_on_entry: assert property (@(posedge clock) disable iff (reset)
        (state_reg == ST_IDLE && enable && below_s && tmr_reg >= DEAD_LAST)
        |=> hs_reg && !ls_reg)
        else $error("on-interval did not start");
    a_on_length: assert property (@(posedge clock) disable iff (reset)
        (state_reg == ST_ON && tmr_reg == on_len_reg - 16'h0001 && enable) |=> !hs_reg)
        else $error("on-interval length wrong");
    a_off_drive: assert property (@(posedge clock) disable iff (reset)
        state_reg == ST_OFF |-> ls_reg && !hs_reg)
        else $error("off-interval drive wrong");
    a_min_off: assert property (@(posedge clock) disable iff (reset)
        $rose(state_reg == ST_DEAD_HS) |-> off_reg >= MIN_OFF)
        else $error("off-interval shorter than minimum");
    a_retrigger: assert property (@(posedge clock) disable iff (reset)
        (state_reg == ST_OFF && enable && !hiccup && below_s && off_reg >= MIN_OFF)
        |=> state_reg == ST_DEAD_HS ##6 hs_reg)
        else $error("next on-interval not triggered");
    a_clamp_hold: assert property (@(posedge clock) disable iff (reset)
        (power_stage_supply_mv >= CLAMP_MV && $past(power_stage_supply_mv) >= CLAMP_MV
        && $stable(output_voltage_mv)) |=> $stable(est_reg))
        else $error("estimate moved above the supply clamp");
    a_ss_step: assert property (@(posedge clock) disable iff (reset)
        (enable && !hiccup && !done_reg && ss_tmr_reg == SS_LAST)
        |=> ref_reg == $past(ref_reg) + 7'h01)
        else $error("soft-start step missed");
    a_ss_hold: assert property (@(posedge clock) disable iff (reset)
        (done_reg && enable && !hiccup) |=> ref_reg == REF_LAST && ss_tmr_reg == TMR_RESET)
        else $error("ramp active after completion");
    a_limit_trip: assert property (@(posedge clock) disable iff (reset)
        hiccup |=> !hs_reg && !ls_reg && ref_reg == REF_RESET)
        else $error("current limit not acted on");
    a_disabled_low: assert property (@(posedge clock) disable iff (reset)
        !enable |=> !hs_reg && !ls_reg && ref_reg == REF_RESET)
        else $error("outputs active while disabled");
endmodule

//--- tb/aotbs_fet_model.sv
/*
 model of the external high-side and low-side switches of the buck stage.
 assumes both gate drives come straight from the sequencer; the sense output
 stands for the low-side drain voltage comparison done by analog circuitry.
*/
module aotbs_fet_model (
    input wire logic high_side_gate_drive,
    input wire logic low_side_gate_drive,
    input wire logic trip_request,
    output logic current_limit_trip,
    output int overlap_count
);
    timeunit 1ns;
    timeprecision 100ps;

    // the drain is only sensed while the low side conducts, else it reads low
    assign current_limit_trip = trip_request & low_side_gate_drive;

    // count every moment both switches would conduct together
    initial overlap_count = 0;
    always @(high_side_gate_drive or low_side_gate_drive)
    begin
        if (high_side_gate_drive === 1'b1 && low_side_gate_drive === 1'b1)
            overlap_count++;
    end
endmodule

//--- tb/test_aotbs_sequencer.sv
/*
 self-checking bench of the adaptive on-time buck sequencer.
 assumes a 5 ns clock and a shortened soft-start step of 4 cycles; inputs
 change 1 ns after each rising edge, outputs are read at that same moment.
*/
module test_aotbs_sequencer;
    import aotbs_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int SSC = 4;
    logic clock, reset, enable, feedback_below_ref, trip_request, current_limit_trip;
    logic [MV_W-1:0] vout, vin;
    logic hs, ls, done;
    logic [REF_W-1:0] ref_step;
    int err_count, checks, overlap_count, n, i;
    // table rows: output mV, supply mV, expected on-interval in cycles
    logic [MV_W-1:0] row_out [4] = '{16'h0708, 16'h0ce4, 16'h03e8, 16'h0320};
    logic [MV_W-1:0] row_sup [4] = '{16'h5dc0, 16'h2ee0, 16'h8ca0, 16'h9c40};
    int row_len [4] = '{50, 184, 23, 18};

    aotbs_sequencer #(.SS_STEP_CYCLES(SSC)) dut (
        .clock(clock),
        .reset(reset),
        .enable(enable),
        .feedback_below_ref(feedback_below_ref),
        .current_limit_trip(current_limit_trip),
        .output_voltage_mv(vout),
        .power_stage_supply_mv(vin),
        .high_side_gate_drive(hs),
        .low_side_gate_drive(ls),
        .reference_step(ref_step),
        .soft_start_done(done)
    );

    aotbs_fet_model fets (
        .high_side_gate_drive(hs),
        .low_side_gate_drive(ls),
        .trip_request(trip_request),
        .current_limit_trip(current_limit_trip),
        .overlap_count(overlap_count)
    );

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic chk(input bit ok, input string msg);
        checks++;
        if (!ok)
        begin
            err_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic test_done;
        if (err_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask

    // wait for a gate (0 high side, 1 low side) to reach v, counting cycles
    task automatic wait_gate(input bit which, input logic v, output int cnt);
        cnt = 0;
        while ((which ? ls : hs) !== v)
        begin
            tick(1);
            cnt++;
            if (cnt > 3000)
            begin
                chk(1'b0, "gate wait ran out");
                test_done();
            end
        end
    endtask

    initial
    begin
        err_count = 0;
        checks = 0;
        reset = 1'b1;
        enable = 1'b0;
        feedback_below_ref = 1'b0;
        trip_request = 1'b0;
        vout = 16'h0708;
        vin = 16'h5dc0;
        tick(6);
        chk({hs, ls, ref_step, done} === 10'h000, "outputs not idle in reset");
        reset = 1'b0;
        tick(1);
        enable = 1'b1;
        // soft-start staircase to full scale
        n = 0;
        while (done !== 1'b1 && n < 400)
        begin
            tick(1);
            n++;
        end
        chk(n >= 83 * SSC - 2 && n <= 83 * SSC + 2, "ramp length wrong");
        chk(ref_step === 7'd83, "ramp end value wrong");
        tick(20);
        chk(ref_step === 7'd83 && done === 1'b1, "reference not held");
        // on-interval per table row, dead times both ways
        for (i = 0; i < 4; i++)
        begin
            vout = row_out[i];
            vin = row_sup[i];
            tick(3);
            feedback_below_ref = 1'b1;
            if (i > 0)
            begin
                wait_gate(1'b1, 1'b0, n);
                wait_gate(1'b0, 1'b1, n);
                chk(n == 6, "low-to-high dead time wrong");
            end
            else
                wait_gate(1'b0, 1'b1, n);
            chk(ls === 1'b0, "low side on during on-interval");
            feedback_below_ref = 1'b0;
            wait_gate(1'b0, 1'b0, n);
            chk(n == row_len[i], "on-interval length wrong");
            wait_gate(1'b1, 1'b1, n);
            chk(n == 6, "high-to-low dead time wrong");
            tick(100);
            chk(ls === 1'b1 && hs === 1'b0, "off-interval not held");
        end
        // load step: comparator keeps reporting feedback below reference across the off-interval
        vout = 16'h0708;
        vin = 16'h5dc0;
        tick(3);
        feedback_below_ref = 1'b1;
        wait_gate(1'b0, 1'b1, n);
        wait_gate(1'b0, 1'b0, n);
        wait_gate(1'b0, 1'b1, n);
        chk(n >= 79 && n <= 80, "forced off-interval length wrong");
        feedback_below_ref = 1'b0;
        wait_gate(1'b1, 1'b1, n);
        // trip inside the blanking window is ignored
        trip_request = 1'b1;
        tick(20);
        trip_request = 1'b0;
        tick(20);
        chk(ls === 1'b1, "trip seen during blanking");
        trip_request = 1'b1;
        wait_gate(1'b1, 1'b0, n);
        chk(n <= 6 && hs === 1'b0, "current limit not acted on");
        tick(1);
        chk(ref_step < 7'd2 && done === 1'b0, "soft-start not restarted");
        trip_request = 1'b0;
        // disable while switching
        feedback_below_ref = 1'b1;
        wait_gate(1'b0, 1'b1, n);
        enable = 1'b0;
        tick(1);
        chk({hs, ls, ref_step, done} === 10'h000, "disable not immediate");
        tick(10);
        chk(hs === 1'b0 && ref_step === 7'd0, "switching while disabled");
        chk(overlap_count == 0, "both switches on together");
        test_done();
    end
endmodule
